// [src/tcd_pkg.sv]
// Notes on behaviour
// - Bit 0 clear selects normal switched channel.
// - Bit 15 gates law conversion by high word.
// - Bit 14 picks constant or variable delay.
// - Bits 13-9 give source stream number.
// - Bits 8-1 give source channel number.
// - Bit 0 set: bits 2-1 pick mode.
// - Message mode outputs bits 10-3 only.
// - Special mode converts message data only.
// - Equal input/output laws mean no translation.
// - Address bit 13 reaches memory; select word.
package tcd_pkg;

  // ---------------------------------------------
  // Host port layout
  // ---------------------------------------------
  localparam int ADDR_W = 14;
  localparam int MEM_SEL_BIT = 13;
  localparam int STR_ADDR_LSB = 8;
  localparam int WORD_W = 16;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'h0000;

  // ---------------------------------------------
  // Low connection word fields
  // ---------------------------------------------
  localparam int SPECIAL_BIT = 0;
  localparam int CONV_BIT = 15;
  localparam int VAR_BIT = 14;
  localparam int STREAM_LSB = 9;
  localparam int STREAM_W = 5;
  localparam int CHAN_LSB = 1;
  localparam int CHAN_W = 8;
  localparam int MODE_LSB = 1;
  localparam int MSG_LSB = 3;
  localparam int MSG_W = 8;
  localparam logic [1:0] PCC_TRISTATE = 2'b00;
  localparam logic [1:0] PCC_MESSAGE = 2'b01;
  localparam logic [1:0] PCC_BER = 2'b10;

  // ---------------------------------------------
  // High connection word fields
  // ---------------------------------------------
  localparam int OCL_LSB = 0;
  localparam int ICL_LSB = 2;
  localparam int LAW_W = 2;
  localparam int VD_BIT = 4;

  // ---------------------------------------------
  // Decoded entry layout in the queue
  // ---------------------------------------------
  localparam int F_MODE = 0;
  localparam int F_STREAM = 3;
  localparam int F_CHAN = 8;
  localparam int F_VAR = 16;
  localparam int F_MSG = 17;
  localparam int F_CONV = 25;
  localparam int F_XLATE = 26;
  localparam int F_ICL = 27;
  localparam int F_OCL = 29;
  localparam int F_VD = 31;
  localparam int F_HIZ = 32;
  localparam int FIFO_W = 33;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_TRISTATE = 3'b001,
    MODE_MESSAGE  = 3'b010,
    MODE_BER      = 3'b011,
    MODE_RESERVED = 3'b100
  } tcd_mode_t;

endpackage

// [src/tcd_fifo.sv]
module tcd_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  // Refuse sizes the pointer logic cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("tcd_fifo: depth must be 2 or more, width 1 or more");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] cnt_ff;
  logic [PW:0] nxt_cnt;
  logic in_ready_ff;
  logic push;
  logic pop;

  assign push = in_valid && in_ready_ff;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign in_ready = in_ready_ff;

  // Occupancy; ready is a flop so it cannot glitch back to the source
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      in_ready_ff <= (nxt_cnt < (PW+1)'(DEPTH));
    end
  end

  // Pointers wrap at depth, so any depth of 2 or more works
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // Storage is written only, never reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule

// [src/tcd_decoder.sv]
module tcd_decoder
  import tcd_pkg::*;
#(
  parameter int STR_BITS = 1,
  parameter int CHN_BITS = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [tcd_pkg::ADDR_W-1:0] host_addr,
  input wire logic [tcd_pkg::WORD_W-1:0] host_wdata,
  output logic [tcd_pkg::WORD_W-1:0] host_rdata,
  input wire logic word_high_select,
  input wire logic variable_delay_global_enable,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [STR_BITS+CHN_BITS-1:0] req_chan,
  output logic out_valid,
  input wire logic out_ready,
  output tcd_pkg::tcd_mode_t out_mode,
  output logic [tcd_pkg::STREAM_W-1:0] out_src_stream,
  output logic [tcd_pkg::CHAN_W-1:0] out_src_chan,
  output logic out_var_delay,
  output logic [tcd_pkg::MSG_W-1:0] out_msg,
  output logic out_conv_en,
  output logic out_xlate,
  output logic [tcd_pkg::LAW_W-1:0] out_icl,
  output logic [tcd_pkg::LAW_W-1:0] out_ocl,
  output logic out_voice_data,
  output logic out_hiz
);
  import tcd_pkg::*;

  localparam int IDX_W = STR_BITS + CHN_BITS;
  localparam int ENTRIES = 1 << IDX_W;

  // Index fields must fit the stream and channel address bits
  if (STR_BITS < 1 || STR_BITS > 5 || CHN_BITS < 1 || CHN_BITS > 8) begin : g_bad_size
    $error("tcd_decoder: stream bits 1..5, channel bits 1..8");
  end

  // ---------------------------------------------
  // Connection memory, host side
  // ---------------------------------------------
  logic [WORD_W-1:0] conn_low_ff [ENTRIES];
  logic [WORD_W-1:0] conn_high_ff [ENTRIES];
  logic [WORD_W-1:0] host_rdata_ff;
  logic [IDX_W-1:0] host_idx;
  logic host_hit;

  // Addresses beyond the implemented streams/channels are not decoded
  assign host_idx = {host_addr[STR_ADDR_LSB +: STR_BITS], host_addr[CHN_BITS-1:0]};
  assign host_hit = host_addr[MEM_SEL_BIT]
    && (host_addr[MEM_SEL_BIT-1:STR_ADDR_LSB] >> STR_BITS) == '0
    && (host_addr[STR_ADDR_LSB-1:0] >> CHN_BITS) == '0;

  // Word select picks low or high half of the entry
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ENTRIES; i++) begin
        conn_low_ff[i] <= LOW_RST;
        conn_high_ff[i] <= HIGH_RST;
      end
    end else if (host_wr && host_hit) begin
      if (word_high_select) begin
        conn_high_ff[host_idx] <= host_wdata;
      end else begin
        conn_low_ff[host_idx] <= host_wdata;
      end
    end
  end

  // Reads return data one cycle later; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_ff <= '0;
    end else if (host_rd) begin
      if (!host_hit) begin
        host_rdata_ff <= '0;
      end else if (word_high_select) begin
        host_rdata_ff <= conn_high_ff[host_idx];
      end else begin
        host_rdata_ff <= conn_low_ff[host_idx];
      end
    end
  end
  assign host_rdata = host_rdata_ff;

  // ---------------------------------------------
  // Per-channel decode
  // ---------------------------------------------
  logic [WORD_W-1:0] cur_low;
  logic [WORD_W-1:0] cur_high;
  logic [FIFO_W-1:0] dec_word;
  tcd_mode_t dec_mode;
  logic [LAW_W-1:0] dec_icl;
  logic [LAW_W-1:0] dec_ocl;
  logic dec_conv;

  assign cur_low = conn_low_ff[req_chan];
  assign cur_high = conn_high_ff[req_chan];
  assign dec_icl = cur_high[ICL_LSB +: LAW_W];
  assign dec_ocl = cur_high[OCL_LSB +: LAW_W];

  // Mode from the special bit and the two-bit mode field
  always_comb begin
    dec_mode = MODE_NORMAL;
    if (cur_low[SPECIAL_BIT]) begin
      case (cur_low[MODE_LSB +: 2])
        PCC_TRISTATE: dec_mode = MODE_TRISTATE;
        PCC_MESSAGE: dec_mode = MODE_MESSAGE;
        PCC_BER: dec_mode = MODE_BER;
        default: dec_mode = MODE_RESERVED;
      endcase
    end
  end

  // Conversion only for switched or message data; the high word is read
  // when the request is queued, so it must already hold its final law codes
  assign dec_conv = cur_low[CONV_BIT]
    && (dec_mode == MODE_NORMAL || dec_mode == MODE_MESSAGE);

  // Pack fields; fields unused by a mode go out as zero. Bits 14-11 are
  // never looked at in special mode, so stray ones do no harm.
  always_comb begin
    dec_word = '0;
    dec_word[F_MODE +: 3] = dec_mode;
    if (dec_mode == MODE_NORMAL) begin
      dec_word[F_STREAM +: STREAM_W] = cur_low[STREAM_LSB +: STREAM_W];
      dec_word[F_CHAN +: CHAN_W] = cur_low[CHAN_LSB +: CHAN_W];
      dec_word[F_VAR] = cur_low[VAR_BIT] && variable_delay_global_enable;
    end
    if (dec_mode == MODE_MESSAGE) begin
      dec_word[F_MSG +: MSG_W] = cur_low[MSG_LSB +: MSG_W];
    end
    dec_word[F_CONV] = dec_conv;
    if (dec_conv) begin
      dec_word[F_XLATE] = (dec_icl != dec_ocl);
      dec_word[F_ICL +: LAW_W] = dec_icl;
      dec_word[F_OCL +: LAW_W] = dec_ocl;
      dec_word[F_VD] = cur_high[VD_BIT];
    end
    // Reserved mode is kept off the line as the safe choice
    dec_word[F_HIZ] = (dec_mode == MODE_TRISTATE)
      || (dec_mode == MODE_RESERVED);
  end

  // ---------------------------------------------
  // Queue toward the output channel logic
  // ---------------------------------------------
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic out_load;
  logic out_valid_ff;
  logic [FIFO_W-1:0] out_word_ff;

  tcd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(dec_word),
    .out_valid(fifo_out_valid),
    .out_ready(out_load),
    .out_data(fifo_out_data)
  );

  // Output stage refills when empty or when its entry is taken
  assign out_load = !out_valid_ff || out_ready;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_ff <= 1'b0;
      out_word_ff <= '0;
    end else if (out_load) begin
      out_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) begin
        out_word_ff <= fifo_out_data;
      end
    end
  end

  assign out_valid = out_valid_ff;
  assign out_mode = tcd_mode_t'(out_word_ff[F_MODE +: 3]);
  assign out_src_stream = out_word_ff[F_STREAM +: STREAM_W];
  assign out_src_chan = out_word_ff[F_CHAN +: CHAN_W];
  assign out_var_delay = out_word_ff[F_VAR];
  assign out_msg = out_word_ff[F_MSG +: MSG_W];
  assign out_conv_en = out_word_ff[F_CONV];
  assign out_xlate = out_word_ff[F_XLATE];
  assign out_icl = out_word_ff[F_ICL +: LAW_W];
  assign out_ocl = out_word_ff[F_OCL +: LAW_W];
  assign out_voice_data = out_word_ff[F_VD];
  assign out_hiz = out_word_ff[F_HIZ];

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  sequence s_low_write;
    host_wr && host_hit && !word_high_select;
  endsequence

  sequence s_same_read;
    host_rd && !host_wr && !word_high_select && host_addr == $past(host_addr);
  endsequence

  a_normal_no_msg: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && out_mode == MODE_NORMAL |-> !out_hiz && out_msg == '0)
    else $error("normal channel shows message or high impedance");
  a_conv_gated: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && (out_mode == MODE_TRISTATE || out_mode == MODE_BER) |-> !out_conv_en)
    else $error("conversion on in tristate or test mode");
  a_law_equal: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && (out_icl == out_ocl || !out_conv_en) |-> !out_xlate)
    else $error("translation with equal laws or conversion off");
  a_var_normal: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && out_var_delay |-> out_mode == MODE_NORMAL)
    else $error("variable delay outside normal switching");
  a_msg_only: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && out_mode != MODE_MESSAGE |-> out_msg == '0)
    else $error("message byte outside message mode");
  a_tristate_hiz: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && out_mode == MODE_TRISTATE |-> out_hiz)
    else $error("tristate channel not high impedance");
  a_host_readback: assert property (@(posedge mclk) disable iff (!rst_b)
    s_low_write ##1 s_same_read |=> host_rdata == $past(host_wdata, 2))
    else $error("low word read back differs from write");
  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_b)
    host_rd && !host_addr[MEM_SEL_BIT] |=> host_rdata == '0)
    else $error("register-space read returned memory data");
  a_out_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    out_valid && !out_ready |=> out_valid && $stable(out_src_stream) && $stable(out_mode))
    else $error("stalled entry changed");

endmodule

// [sim/tcd_sink_model.sv]
module tcd_sink_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [32:0] entry
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [32:0] got[$];
  // Output slot logic: ready moves off the sampling edge, may stall for back-pressure
  initial out_ready = 1'b0;
  always @(negedge mclk) begin
    out_ready <= rst_b && !stall;
  end
  // Entry retires on the edge where both valid and ready are seen
  always @(posedge mclk) begin
    if (rst_b && out_valid && out_ready) begin
      got.push_back(entry);
    end
  end
endmodule

// [sim/tcd_decoder_tb_top.sv]
module tcd_decoder_tb_top;
  import tcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_b = 1'b0, host_wr = 1'b0, host_rd = 1'b0, word_high_select = 1'b0;
  logic [13:0] host_addr = 14'h0000;
  logic [15:0] host_wdata = 16'h0000, host_rdata, rv;
  logic variable_delay_global_enable = 1'b0, req_valid = 1'b0, req_ready, stall = 1'b0;
  logic [2:0] req_chan = 3'h0;
  logic out_valid, out_ready, out_conv_en, out_xlate, out_voice_data, out_hiz, out_var_delay;
  tcd_mode_t out_mode;
  logic [4:0] out_src_stream;
  logic [7:0] out_src_chan, out_msg;
  logic [1:0] out_icl, out_ocl;
  logic [32:0] entry;
  int mismatches = 0, total_checks = 0;
  assign entry = {out_mode, out_src_stream, out_src_chan, out_var_delay, out_msg,
                  out_conv_en, out_xlate, out_icl, out_ocl, out_voice_data, out_hiz};
  always #50 mclk = ~mclk;
  tcd_decoder #(.STR_BITS(1), .CHN_BITS(2)) dut (.mclk(mclk), .rst_b(rst_b),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .word_high_select(word_high_select),
    .variable_delay_global_enable(variable_delay_global_enable), .req_valid(req_valid),
    .req_ready(req_ready), .req_chan(req_chan), .out_valid(out_valid), .out_ready(out_ready),
    .out_mode(out_mode), .out_src_stream(out_src_stream), .out_src_chan(out_src_chan),
    .out_var_delay(out_var_delay), .out_msg(out_msg), .out_conv_en(out_conv_en),
    .out_xlate(out_xlate), .out_icl(out_icl), .out_ocl(out_ocl),
    .out_voice_data(out_voice_data), .out_hiz(out_hiz));
  tcd_sink_model sink (.mclk(mclk), .rst_b(rst_b), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .entry(entry));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      mismatches++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Memory hit: top select bit set, stream in bit 8, channel in bits 1-0
  function automatic logic [13:0] addr_of(input logic [2:0] idx);
    return {1'b1, 4'h0, idx[2], 6'h00, idx[1:0]};
  endfunction
  // Expected decoded entry, fields zero where a mode leaves them unused
  function automatic logic [32:0] exp_of(input logic [15:0] lo, input logic [15:0] hi,
                                          input logic gen);
    logic [2:0] md;
    logic [12:0] sc;
    logic [7:0] mg;
    logic cv;
    logic vr;
    logic hz;
    md = 3'h0;
    sc = lo[13:1];
    vr = lo[14] & gen;
    mg = 8'h00;
    cv = lo[15];
    hz = 1'b0;
    if (lo[0]) begin
      md = {1'b0, lo[2:1]} + 3'h1;
      sc = 13'h0000;
      vr = 1'b0;
      cv = (lo[2:1] == 2'b01) & lo[15];
      mg = (lo[2:1] == 2'b01) ? lo[10:3] : 8'h00;
      hz = (lo[2:1] == 2'b00) || (lo[2:1] == 2'b11);
    end
    // Entry order is input law, output law, then voice/data class
    return {md, sc, vr, mg, cv, cv && (hi[3:2] != hi[1:0]), cv ? {hi[3:0], hi[4]} : 5'h00, hz};
  endfunction
  task automatic wr(input logic [13:0] a, input logic [15:0] d, input logic hi);
    @(negedge mclk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    word_high_select = hi;
    @(negedge mclk);
    host_wr = 1'b0;
  endtask
  task automatic rd(input logic [13:0] a, input logic hi, output logic [15:0] d);
    @(negedge mclk);
    host_rd = 1'b1;
    host_addr = a;
    word_high_select = hi;
    @(negedge mclk);
    host_rd = 1'b0;
    d = host_rdata;
  endtask
  task automatic wait_got(input int k);
    for (int i = 0; i < 100 && sink.got.size() < k; i++) @(negedge mclk);
  endtask
  // Request held until an edge sees ready, then released
  task automatic decode(input logic [2:0] idx, input logic [15:0] lo, input logic [15:0] hi,
                        input logic gen);
    int base;
    base = sink.got.size();
    variable_delay_global_enable = gen;
    wr(addr_of(idx), hi, 1'b1);
    wr(addr_of(idx), lo, 1'b0);
    @(negedge mclk);
    req_valid = 1'b1;
    req_chan = idx;
    for (int i = 0; i < 50 && !req_ready; i++) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    wait_got(base + 1);
    check("entry", sink.got[base], exp_of(lo, hi, gen));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_normal();
    decode(3'h5, 16'h0000, 16'h0000, 1'b0);
    decode(3'h1, 16'hFFFE, 16'h001D, 1'b0);
    decode(3'h2, 16'hC2A4, 16'h0006, 1'b1);
    decode(3'h3, 16'h8000, 16'h0005, 1'b1);
    decode(3'h4, 16'h7FFE, 16'h0009, 1'b1);
  endtask
  task automatic t_special();
    for (int p = 0; p < 4; p++) begin
      decode(3'h7, 16'h852D & 16'hFFF9 | 16'(p << 1), 16'h0016, 1'b1);
    end
    decode(3'h7, 16'h7FFB, 16'h0016, 1'b1);
  endtask
  task automatic t_host();
    wr(addr_of(3'h6), 16'h1234, 1'b0);
    wr(addr_of(3'h6), 16'h0013, 1'b1);
    rd(addr_of(3'h6), 1'b0, rv);
    check("low word", 33'(rv), 33'h0_0000_1234);
    rd(addr_of(3'h6), 1'b1, rv);
    check("high word", 33'(rv), 33'h0_0000_0013);
    wr(14'h0106, 16'hFFFF, 1'b0);
    rd(14'h0106, 1'b0, rv);
    check("unmapped", 33'(rv), 33'h0_0000_0000);
    rd(addr_of(3'h6), 1'b0, rv);
    check("kept word", 33'(rv), 33'h0_0000_1234);
    // Write then read on the very next edge must return the new word
    @(negedge mclk);
    host_wr = 1'b1;
    host_addr = addr_of(3'h0);
    host_wdata = 16'h5A5A;
    word_high_select = 1'b0;
    @(negedge mclk);
    host_wr = 1'b0;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    check("write then read", 33'(host_rdata), 33'h0_0000_5A5A);
  endtask
  // Stalled consumer: queue fills until refused, then drains in order
  task automatic t_fill();
    int n;
    int base;
    logic took;
    n = 0;
    stall = 1'b1;
    wr(addr_of(3'h1), 16'h3C3C, 1'b0);
    wr(addr_of(3'h2), 16'h0A52, 1'b0);
    base = sink.got.size();
    @(negedge mclk);
    req_valid = 1'b1;
    req_chan = 3'h1;
    for (int i = 0; i < 40; i++) begin
      took = req_ready;
      @(negedge mclk);
      if (took) begin
        n++;
        req_chan = req_chan ^ 3'h3;
      end
    end
    req_valid = 1'b0;
    // Queue depth plus the one entry parked in the output stage
    check("fill count", 33'(n), 33'(FIFO_DEPTH + 1));
    check("full refuses", 33'(req_ready), 33'h0_0000_0000);
    stall = 1'b0;
    wait_got(base + n);
    for (int k = 0; k < n; k++) begin
      check("drain", sink.got[base + k], exp_of(k[0] ? 16'h0A52 : 16'h3C3C, 16'h0000, 1'b0));
    end
    check("ready again", 33'(req_ready), 33'h0_0000_0001);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    check("rdata in reset", 33'(host_rdata), 33'h0_0000_0000);
    @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    rd(addr_of(3'h0), 1'b0, rv);
    check("reset word", 33'(rv), 33'h0_0000_0000);
    t_normal();
    t_special();
    t_host();
    t_fill();
    summarize();
  end
  // Run needs well under a thousand cycles
  initial begin
    #500_000;
    mismatches++;
    summarize();
  end
endmodule
